// ### dtte_map.vh
// Purpose: constants of the trigger-driven transfer engine
// Assumes: one clock, no software-reachable registers
// Notes: channel setup arrives on plain ports
`ifndef DTTE_MAP_VH
`define DTTE_MAP_VH

`define DTTE_ST_IDLE 2'h0
`define DTTE_ST_READ 2'h1
`define DTTE_ST_WRITE 2'h2
`define DTTE_ST_DONE 2'h3

`define DTTE_ONE_CH 3'h1
`define DTTE_ZERO_SZ 16'h0000
`define DTTE_ONE_SZ 16'h0001
`define DTTE_ONE_ADDR 16'h0001

`endif

// ### dtte_buf2.v
// Purpose: two-entry valid/ready buffer for read data
// Assumes: single clock
// Notes: full throughput, stall on the drain side fills it
`timescale 1ns/100ps
module dtte_buf2 #(
  parameter W = 24
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // fill side
  input wire inValid,
  output wire inReady,
  input wire [W-1:0] inData,
  // drain side
  output wire outValid,
  input wire outReady,
  output wire [W-1:0] outData
);
  reg [W-1:0] mem0_reg;
  reg [W-1:0] mem1_reg;
  reg [1:0] cnt_reg;
  reg rdPtr_reg;
  reg wrPtr_reg;
  wire push;
  wire pop;

  assign inReady = (cnt_reg != 2'h2);
  assign outValid = (cnt_reg != 2'h0);
  assign outData = rdPtr_reg ? mem1_reg : mem0_reg;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem0_reg <= {W{1'b0}};
      mem1_reg <= {W{1'b0}};
      cnt_reg <= 2'h0;
      rdPtr_reg <= 1'b0;
      wrPtr_reg <= 1'b0;
    end else begin
      if (push) begin
        if (wrPtr_reg) begin
          mem1_reg <= inData;
        end else begin
          mem0_reg <= inData;
        end
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (pop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 2'h1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end
  end
endmodule

// ### dtte_engine.v
// Purpose: multi-channel trigger-driven byte transfer engine
// Assumes: triggers may come from foreign clocks; bus answers with wait
// Notes: one transfer per trigger edge, fixed priority by channel number
`timescale 1ns/100ps
`include "dtte_map.vh"
module dtte_engine #(
  parameter NCH = 3,
  parameter AW = 16,
  parameter SW = 16
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // raw trigger flags, one per channel, any clock
  input wire [NCH-1:0] trigIn,
  // channel setup
  input wire [NCH-1:0] chEnable,
  input wire [NCH-1:0] chLoad,
  input wire [NCH*AW-1:0] loadSrc,
  input wire [NCH*AW-1:0] loadDst,
  input wire [NCH*SW-1:0] loadSize,
  // debug halt request
  input wire haltReq,
  // memory bus
  output reg busReq,
  output reg busWrite,
  output reg [AW-1:0] busAddr,
  output reg [7:0] busWdata,
  input wire [7:0] busRdata,
  input wire busWait,
  // per-channel flag clear and completion pulses, halt status
  output reg [NCH-1:0] flagClr,
  output reg [NCH-1:0] chDone,
  output reg halted
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one-hot of the lowest set bit: fixed priority
  function [NCH-1:0] lowestBit;
    input [NCH-1:0] v;
    integer k;
    reg found;
    begin
      lowestBit = {NCH{1'b0}};
      found = 1'b0;
      for (k = 0; k < NCH; k = k + 1) begin
        if (v[k] && !found) begin
          lowestBit[k] = 1'b1;
          found = 1'b1;
        end
      end
    end
  endfunction

  // index of a one-hot vector
  function [1:0] chIndex;
    input [NCH-1:0] oneHot;
    integer k;
    begin
      chIndex = 2'h0;
      for (k = 0; k < NCH; k = k + 1) begin
        if (oneHot[k]) begin
          chIndex = k[1:0];
        end
      end
    end
  endfunction

  // one channel's address out of a packed table
  function [AW-1:0] pickAddr;
    input [NCH*AW-1:0] tbl;
    input [1:0] idx;
    begin
      pickAddr = tbl[idx*AW +: AW];
    end
  endfunction

  // next byte address
  function [AW-1:0] bumpAddr;
    input [AW-1:0] a;
    begin
      bumpAddr = a + `DTTE_ONE_ADDR;
    end
  endfunction

  // ----------------------------------------------------------------
  // trigger synchronisers and edge capture
  // ----------------------------------------------------------------
  reg [NCH-1:0] syncA_reg;
  reg [NCH-1:0] syncB_reg;
  reg [NCH-1:0] syncC_reg;
  reg [NCH-1:0] pend_reg;
  wire [NCH-1:0] trigEdge;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg <= {NCH{1'b0}};
      syncB_reg <= {NCH{1'b0}};
      syncC_reg <= {NCH{1'b0}};
    end else begin
      syncA_reg <= trigIn;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  assign trigEdge = syncB_reg & ~syncC_reg;

  // ----------------------------------------------------------------
  // channel state
  // ----------------------------------------------------------------
  reg [NCH*AW-1:0] src_reg;
  reg [NCH*AW-1:0] dst_reg;
  reg [NCH*SW-1:0] size_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] cur_reg;
  reg [NCH-1:0] curHot_reg;
  wire [NCH-1:0] grant;
  wire [NCH-1:0] startHot;
  wire [SW-1:0] curSize;
  wire [AW-1:0] curSrc;
  wire [AW-1:0] curDst;

  // buffer between the read and write halves of a transfer
  wire bufInReady;
  wire bufOutValid;
  wire [AW+7:0] bufOutData;
  reg bufPush;
  reg bufPop;

  assign grant = lowestBit(pend_reg & chEnable);
  assign startHot = (state_reg == `DTTE_ST_IDLE && !haltReq) ?
    grant : {NCH{1'b0}};
  assign curSize = size_reg[cur_reg*SW +: SW];
  assign curSrc = pickAddr(src_reg, cur_reg);
  assign curDst = pickAddr(dst_reg, cur_reg);

  // ----------------------------------------------------------------
  // pending edges
  // ----------------------------------------------------------------
  // set wins over the serve clear, disable drops it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= {NCH{1'b0}};
    end else begin
      pend_reg <= ((pend_reg & ~startHot) | trigEdge) & chEnable
        & ~chLoad;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    bufPush = 1'b0;
    bufPop = 1'b0;
    case (state_reg)
      `DTTE_ST_IDLE: begin
        if (|startHot) begin
          state_next = `DTTE_ST_READ;
        end
      end
      `DTTE_ST_READ: begin
        // hold the access while the peripheral stretches it
        if (!busWait && bufInReady) begin
          bufPush = 1'b1;
          state_next = `DTTE_ST_WRITE;
        end
      end
      `DTTE_ST_WRITE: begin
        // a halt never cuts a write short
        if (bufOutValid && !busWait) begin
          bufPop = 1'b1;
          state_next = `DTTE_ST_DONE;
        end
      end
      `DTTE_ST_DONE: begin
        state_next = `DTTE_ST_IDLE;
      end
      default: begin
        state_next = `DTTE_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // read/write buffer
  // ----------------------------------------------------------------
  dtte_buf2 #(
    .W(AW + 8)
  ) uBuf (
    .clk(clk),
    .rstn(rstn),
    .inValid(bufPush),
    .inReady(bufInReady),
    .inData({curDst, busRdata}),
    .outValid(bufOutValid),
    .outReady(bufPop),
    .outData(bufOutData)
  );

  // ----------------------------------------------------------------
  // channel table
  // ----------------------------------------------------------------
  integer i;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_reg <= {NCH*AW{1'b0}};
      dst_reg <= {NCH*AW{1'b0}};
      size_reg <= {NCH*SW{1'b0}};
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (chLoad[i]) begin
          src_reg[i*AW +: AW] <= loadSrc[i*AW +: AW];
          dst_reg[i*AW +: AW] <= loadDst[i*AW +: AW];
          size_reg[i*SW +: SW] <= loadSize[i*SW +: SW];
        end
      end
      // a reload of the channel in flight loses to the step: disable first
      if (bufPop) begin
        size_reg[cur_reg*SW +: SW] <= curSize - `DTTE_ONE_SZ;
        src_reg[cur_reg*AW +: AW] <= bumpAddr(curSrc);
        dst_reg[cur_reg*AW +: AW] <= bumpAddr(curDst);
      end
    end
  end

  // ----------------------------------------------------------------
  // clear, completion and halt status
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flagClr <= {NCH{1'b0}};
      chDone <= {NCH{1'b0}};
      halted <= 1'b0;
    end else begin
      // the peripheral's flag is cleared by a single pulse,
      // never by read-modify-write, so concurrent sets survive
      flagClr <= bufPush ? curHot_reg : {NCH{1'b0}};
      chDone <= (bufPop && curSize == `DTTE_ONE_SZ) ?
        curHot_reg : {NCH{1'b0}};
      // idle only, so an active write always completes first
      halted <= haltReq && (state_reg == `DTTE_ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= `DTTE_ST_IDLE;
      cur_reg <= 2'h0;
      curHot_reg <= {NCH{1'b0}};
      busReq <= 1'b0;
      busWrite <= 1'b0;
      busAddr <= {AW{1'b0}};
      busWdata <= 8'h00;
    end else begin
      state_reg <= state_next;
      case (state_reg)
        `DTTE_ST_IDLE: begin
          if (|startHot) begin
            cur_reg <= chIndex(startHot);
            curHot_reg <= startHot;
            busReq <= 1'b1;
            busWrite <= 1'b0;
            busAddr <= pickAddr(src_reg, chIndex(startHot));
          end else begin
            busReq <= 1'b0;
            busWrite <= 1'b0;
          end
        end
        `DTTE_ST_READ: begin
          if (bufPush) begin
            busWrite <= 1'b1;
            busAddr <= curDst;
            busWdata <= busRdata;
          end
        end
        `DTTE_ST_WRITE: begin
          if (bufPop) begin
            busReq <= 1'b0;
            busWrite <= 1'b0;
            busAddr <= bufOutData[AW+7:8];
            busWdata <= bufOutData[7:0];
          end
        end
        `DTTE_ST_DONE: begin
          busReq <= 1'b0;
          busWrite <= 1'b0;
        end
        default: begin
          busReq <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### dtte_checker.sv
// Purpose: port-level checks of the transfer engine
// Assumes: one clock, async active-low reset
// Notes: bound to the engine from tb_top
`timescale 1ns/100ps
module dtte_checker #(
  parameter NCH = 3,
  parameter AW = 16
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // engine ports
  input wire [NCH-1:0] trigIn,
  input wire [NCH-1:0] chEnable,
  input wire [NCH-1:0] chLoad,
  input wire haltReq,
  input wire busReq,
  input wire busWrite,
  input wire [AW-1:0] busAddr,
  input wire busWait,
  input wire [NCH-1:0] flagClr,
  input wire [NCH-1:0] chDone,
  input wire halted
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------
  // transfer steps
  // ----------------
  sequence rdEnd;
    busReq && !busWrite && !busWait;
  endsequence
  sequence wrStart;
    busReq && busWrite && flagClr != 0;
  endsequence
  chk_read_then_write: assert property (rdEnd |=> wrStart)
    else $error("write phase missing after read");
  chk_clr_onehot: assert property (flagClr != 0 |-> $onehot(flagClr))
    else $error("flag clear not one channel");
  chk_done_end: assert property (chDone != 0 |-> $fell(busReq))
    else $error("done pulse off transfer end");
  chk_wait_hold: assert property (busReq && busWait |=>
    busReq && $stable(busAddr) && $stable(busWrite))
    else $error("access moved during wait");
  chk_no_start_halt: assert property ($rose(busReq) |-> !$past(haltReq))
    else $error("transfer started under halt");
  chk_halt_idle: assert property (halted |-> !busReq)
    else $error("halted while busy");
  chk_end_write: assert property ($fell(busReq) |-> $past(busWrite))
    else $error("transfer ended outside write");
  chk_edge_served: assert property ($rose(trigIn[0]) && chEnable[0] &&
    !chLoad[0] && !haltReq |-> ##[1:80] flagClr[0])
    else $error("trigger edge not served");
  chk_gap_idle: assert property ($fell(busReq) |-> !busReq [*2])
    else $error("transfers too close");
endmodule

// ### dtte_peer.sv
// Purpose: peripheral side: trigger flags and a waiting bus slave
// Assumes: flags raised by the bench, cleared by the engine
// Notes: read data derives from address so writes are checkable
`timescale 1ns/100ps
module dtte_peer (
  // clock and reset
  input wire clk,
  input wire rstn,
  // flag control
  input wire [2:0] raise,
  input wire [2:0] flagClr,
  input wire share,
  output wire [2:0] trigIn,
  // bus slave
  input wire [3:0] stall,
  input wire busReq,
  input wire busWrite,
  input wire [15:0] busAddr,
  output wire [7:0] busRdata,
  output wire busWait
);
  reg [2:0] flagReg;
  reg [3:0] waitReg;
  reg [7:0] junkReg;
  // share: channel 2 follows flag 0, two channels on one source
  assign trigIn = share ? {flagReg[0], flagReg[1:0]} : flagReg;
  assign busWait = busReq && waitReg != stall;
  // not addressed: churn so a stale sample shows
  assign busRdata = (busReq && !busWrite) ? busAddr[7:0] ^ 8'h5A : junkReg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flagReg <= 3'h0;
      waitReg <= 4'h0;
      junkReg <= 8'h00;
    end else begin
      junkReg <= junkReg + 8'h3B;
      waitReg <= busWait ? waitReg + 4'h1 : 4'h0;
      // a new flag beats the clear
      flagReg <= (flagReg & ~flagClr) | raise;
    end
  end
endmodule

// ### tb_top.sv
// Purpose: self-checking bench of the transfer engine
// Assumes: inputs change on the falling edge
// Notes: one task per scenario
`timescale 1ns/100ps
module tb_top;
  reg clk = 0, rstn = 0, haltReq = 0, share = 0;
  reg [2:0] chEnable = 0, chLoad = 0, raise = 0, firstClr, doneSeen;
  reg [47:0] loadSrc = 0, loadDst = 0, loadSize = 0;
  reg [3:0] stall = 0;
  reg [15:0] wAddr;
  reg [7:0] wData;
  wire [2:0] trigIn, flagClr, chDone;
  wire busReq, busWrite, busWait, halted;
  wire [15:0] busAddr;
  wire [7:0] busWdata, busRdata;
  integer n_errors = 0, n_checks = 0, cyc = 0, nWr = 0, n0;
  always #4 clk = ~clk;
  dtte_engine u_dtte_engine (.clk(clk), .rstn(rstn), .trigIn(trigIn),
    .chEnable(chEnable), .chLoad(chLoad), .loadSrc(loadSrc),
    .loadDst(loadDst), .loadSize(loadSize), .haltReq(haltReq),
    .busReq(busReq), .busWrite(busWrite), .busAddr(busAddr),
    .busWdata(busWdata), .busRdata(busRdata), .busWait(busWait),
    .flagClr(flagClr), .chDone(chDone), .halted(halted));
  dtte_peer u_dtte_peer (.clk(clk), .rstn(rstn), .raise(raise), .share(share),
    .flagClr(flagClr), .trigIn(trigIn), .stall(stall), .busReq(busReq),
    .busWrite(busWrite), .busAddr(busAddr), .busRdata(busRdata),
    .busWait(busWait));
  // ----------------
  // monitor
  // ----------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      test_done;
    end
    if (busReq && busWrite && !busWait) begin
      wAddr <= busAddr;
      wData <= busWdata;
      nWr <= nWr + 1;
    end
    if (flagClr != 0 && firstClr == 0) firstClr <= flagClr;
    doneSeen <= doneSeen | chDone;
  end
  // ----------------
  // helpers
  // ----------------
  task chk(input [8*6-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        $display("BAD %0s exp %h got %h", nm, e, g);
        n_errors = n_errors + 1;
      end
    end
  endtask
  task setup(input integer c, input [15:0] s, input [15:0] d);
    begin
      loadSrc[c*16+:16] = s;
      loadDst[c*16+:16] = d;
      loadSize[c*16+:16] = 16'h0001;
      chLoad[c] = 1'b1;
      @(negedge clk);
      chLoad = 3'h0;
      chEnable[c] = 1'b1;
      firstClr = 3'h0;
      doneSeen = 3'h0;
      n0 = nWr;
      @(negedge clk);
    end
  endtask
  task go(input [2:0] m, input integer n);
    integer k;
    begin
      raise = m;
      @(negedge clk);
      raise = 3'h0;
      for (k = 0; k < 300 && nWr < n0 + n; k = k + 1) @(negedge clk);
      repeat (3) @(negedge clk);
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task t_basic;
    begin
      setup(0, 16'h0100, 16'h0200);
      loadSize[15:0] = 16'h0002;
      chLoad = 3'h1;
      @(negedge clk);
      chLoad = 3'h0;
      go(3'h1, 1);
      chk("addr", 16'h0200, wAddr);
      chk("data", 16'h005A, {8'h00, wData});
      go(3'h1, 2);
      chk("addr", 16'h0201, wAddr);
      chk("data", 16'h005B, {8'h00, wData});
      chk("done", 16'h0001, {13'h0, doneSeen});
    end
  endtask
  task t_prio;
    begin
      setup(0, 16'h0300, 16'h0400);
      setup(2, 16'h0310, 16'h0410);
      go(3'h5, 2);
      chk("first", 16'h0001, {13'h0, firstClr});
      chk("addr", 16'h0410, wAddr);
      chk("done", 16'h0005, {13'h0, doneSeen});
    end
  endtask
  task t_share;
    begin
      share = 1'b1;
      setup(0, 16'h0150, 16'h0250);
      setup(2, 16'h0160, 16'h0260);
      go(3'h1, 2);
      chk("first", 16'h0001, {13'h0, firstClr});
      chk("addr", 16'h0260, wAddr);
      chk("data", 16'h003A, {8'h00, wData});
      chk("done", 16'h0005, {13'h0, doneSeen});
      share = 1'b0;
    end
  endtask
  task t_wait;
    begin
      stall = 4'h3;
      setup(1, 16'h0120, 16'h0220);
      go(3'h2, 1);
      chk("data", 16'h007A, {8'h00, wData});
      chk("done", 16'h0002, {13'h0, doneSeen});
      stall = 4'h0;
    end
  endtask
  task t_halt;
    begin
      haltReq = 1'b1;
      setup(0, 16'h0130, 16'h0230);
      raise = 3'h1;
      repeat (30) @(negedge clk);
      raise = 3'h0;
      chk("held", n0[15:0], nWr[15:0]);
      chk("halted", 16'h0001, {15'h0, halted});
      haltReq = 1'b0;
      go(3'h0, 1);
      chk("data", 16'h006A, {8'h00, wData});
    end
  endtask
  task t_reinit;
    begin
      chEnable = 3'h0;
      n0 = nWr;
      go(3'h4, 0);
      repeat (20) @(negedge clk);
      setup(2, 16'h0140, 16'h0240);
      repeat (30) @(negedge clk);
      chk("drop", n0[15:0], nWr[15:0]);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_basic;
    t_prio;
    t_share;
    t_wait;
    t_halt;
    t_reinit;
    test_done;
  end
endmodule
bind dtte_engine dtte_checker #(.NCH(NCH), .AW(AW)) u_dtte_checker (
  .clk(clk), .rstn(rstn), .trigIn(trigIn), .chEnable(chEnable),
  .chLoad(chLoad), .haltReq(haltReq), .busReq(busReq),
  .busWrite(busWrite), .busAddr(busAddr), .busWait(busWait),
  .flagClr(flagClr), .chDone(chDone), .halted(halted));
